// ### core/let_regs.svh
// register offsets, reset values and timing constants of the link timeout block
`ifndef LET_REGS_SVH
`define LET_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define LET_OFF_CTRL 8'h00
`define LET_OFF_STATUS 8'h04
`define LET_OFF_MASK 8'h08
`define LET_OFF_LOCAL_ED 8'h0C
`define LET_OFF_ED_VAL 8'h10
`define LET_OFF_INFO 8'h14

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define LET_CTRL_SHORT_RT 0
`define LET_INFO_ED_NS 0
`define LET_INFO_LOGGED 1
`define LET_CTRL_RST 32'h0000_0000
`define LET_MASK_RST 6'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LET_CLK_PERIOD_NS 20
`define LET_US_NS 1000
`define LET_TICK_CYC (`LET_US_NS / `LET_CLK_PERIOD_NS)
`define LET_MS_US 1000
`define LET_RT_LONG_MS 100
`define LET_RT_SHORT_US 100
`define LET_ED_DEF_MS 2000
`define LET_RT_SHORT_NS (`LET_RT_SHORT_US * `LET_US_NS)

`endif

// ### core/let_pkg.sv
// types shared by the link timeout block
package let_pkg;

  localparam int unsigned LET_NCH = 6;

  // timer channels
  typedef enum logic [2:0] {
    LET_CH_RT,
    LET_CH_SEQ,
    LET_CH_BUSY,
    LET_CH_ACK,
    LET_CH_EXPIRE,
    LET_CH_RA
  } let_ch_t;

  // timeout value as exchanged during login or in an accept payload
  typedef struct packed {
    logic [31:0] value;
    logic res_ns;
  } let_tov_t;

  // login result seen by the port
  typedef struct packed {
    logic valid;
    logic fabric;
    let_tov_t ed;
  } let_login_t;

  // answer to a read timeout value request
  typedef struct packed {
    logic valid;
    let_tov_t rt;
    let_tov_t ed;
  } let_rtv_t;

endpackage

// ### core/let_top.sv
// timeout engine for one serial-fabric port, with an AXI4-Lite register file
//
// Overview of operation
// - each timeout except the sequence, busy and acknowledgement deadlines runs at least its value and at most 20 percent longer.
// - receiver-transmitter timeout flags loss of synchronization, default 100 ms.
// - optional short 100 us receiver-transmitter timeout, advertised in login parameters.
// - error-detect timeout flags a missing response to a timed event.
// - error-detect timeout defaults to 2 s until login supplies one.
// - after fabric login adopt the fabric port's error-detect value.
// - point-to-point login: both ports use the longer offered error-detect value.
// - reported timeout values count 1 ms or 1 ns units per resolution flag.
// - next data frame of a sequence goes out within one error-detect period.
// - busy-answered class 2 frame is resent within one error-detect period.
// - each acknowledgement goes out within one error-detect period of its event.
// - other actions wait for the full error-detect timeout to expire.
// - resource-allocation timeout is twice the agreed error-detect value.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps

`include "let_regs.svh"

module let_top
  import let_pkg::*;
#(
  parameter int unsigned TICK_CYC = `LET_TICK_CYC,
  parameter int unsigned RT_LONG_US = `LET_RT_LONG_MS * `LET_MS_US,
  parameter int unsigned ED_DEF_MS = `LET_ED_DEF_MS,
  parameter int unsigned TW = 42
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link events
  input wire logic rx_sync,
  input wire logic seq_active,
  input wire logic tx_data_frame,
  input wire logic busy_pending,
  input wire logic tx_retry,
  input wire logic ack_pending,
  input wire logic tx_ack,
  input wire logic wait_run,
  input wire logic wait_start,
  input wire logic ra_run,
  input wire logic ra_start,
  // login and reporting
  input wire let_login_t login,
  input wire logic read_timeout_value_request,
  output let_rtv_t link_service_accept,
  output logic adv_short_rt,
  // expiry pulses and interrupt
  output logic [LET_NCH-1:0] expire,
  output logic irq
);

  // ------------------------------------------------------------
  // prescaler: one tick per microsecond
  // ------------------------------------------------------------
  logic [15:0] pre_q;
  wire tick = (pre_q == 16'(TICK_CYC - 1));

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      pre_q <= 16'h0000;
    else
      pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [LET_NCH-1:0] status_q;
  logic [LET_NCH-1:0] mask_q;
  logic [31:0] local_ed_q;
  let_tov_t ed_q;
  logic logged_q;

  wire short_rt = ctrl_q[`LET_CTRL_SHORT_RT];
  assign adv_short_rt = short_rt;

  // ------------------------------------------------------------
  // error-detect value in microseconds
  // ------------------------------------------------------------
  // ns counts round up so the timer never runs short
  function automatic logic [TW-1:0] to_us(let_tov_t t);
    logic [TW-1:0] r;
    r = '0;
    if (t.res_ns)
      r = (TW'(t.value) + TW'(999)) / TW'(1000);
    else
      r = TW'(t.value) * TW'(`LET_MS_US);
    return r;
  endfunction

  wire [TW-1:0] ed_us = to_us(ed_q);
  wire [TW-1:0] peer_us = to_us(login.ed);
  wire [TW-1:0] own_us = TW'(local_ed_q) * TW'(`LET_MS_US);
  wire let_tov_t own_tov = '{value: local_ed_q, res_ns: 1'b0};
  wire peer_longer = peer_us > own_us;
  wire let_tov_t login_pick = (login.fabric || peer_longer) ? login.ed : own_tov;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ed_q <= '{value: 32'(ED_DEF_MS), res_ns: 1'b0};
      logged_q <= 1'b0;
    end
    else if (login.valid)
    begin
      ed_q <= login_pick;
      logged_q <= 1'b1;
    end

  // ------------------------------------------------------------
  // timer channels
  // ------------------------------------------------------------
  // one extra tick absorbs the phase of the free prescaler, so the
  // wait is never short and overshoots by under one microsecond
  wire [TW-1:0] rt_us = short_rt ? TW'(`LET_RT_SHORT_US) : TW'(RT_LONG_US);
  wire [TW-1:0] ed_up = (ed_us > TW'(1)) ? ed_us - TW'(1) : TW'(1);
  logic [TW-1:0] lim [LET_NCH];
  logic [LET_NCH-1:0] run;
  logic [LET_NCH-1:0] restart;

  assign lim[LET_CH_RT] = rt_us + TW'(1);
  assign lim[LET_CH_SEQ] = ed_up;
  assign lim[LET_CH_BUSY] = ed_up;
  assign lim[LET_CH_ACK] = ed_up;
  assign lim[LET_CH_EXPIRE] = ed_us + TW'(1);
  assign lim[LET_CH_RA] = (ed_us << 1) + TW'(1);

  assign run = {ra_run, wait_run, ack_pending, busy_pending, seq_active, ~rx_sync};
  assign restart = {ra_start, wait_start, tx_ack, tx_retry, tx_data_frame, rx_sync};

  logic [TW-1:0] cnt_q [LET_NCH];
  logic [LET_NCH-1:0] done_q;

  genvar g;
  generate
    for (g = 0; g < LET_NCH; g++)
    begin : g_tmr
      wire hit = run[g] && tick && !done_q[g] && (cnt_q[g] + TW'(1) >= lim[g]);
      assign expire[g] = hit && !restart[g];

      always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
          cnt_q[g] <= '0;
          done_q[g] <= 1'b0;
        end
        else if (restart[g] || !run[g])
        begin
          cnt_q[g] <= '0;
          done_q[g] <= 1'b0;
        end
        else if (tick && !done_q[g])
        begin
          cnt_q[g] <= cnt_q[g] + TW'(1);
          done_q[g] <= hit;
        end
    end
  endgenerate

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire [7:0] wa = aw_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_q ? wstrb_q : s_axi_wstrb;
  wire wr_go = (aw_q || aw_hs) && (w_q || w_hs);
  wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire wr_ctrl = wr_go && (wa == `LET_OFF_CTRL);
  wire wr_stat = wr_go && (wa == `LET_OFF_STATUS);
  wire wr_mask = wr_go && (wa == `LET_OFF_MASK);
  wire wr_led = wr_go && (wa == `LET_OFF_LOCAL_ED);
  wire wr_hit = wr_ctrl || wr_stat || wr_mask || wr_led;
  wire [LET_NCH-1:0] w1c = wr_stat ? (wd[LET_NCH-1:0] & wmask[LET_NCH-1:0]) : '0;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end
    else
    begin
      if (aw_hs)
        awaddr_q <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_q <= wr_go ? 1'b0 : (aw_q || aw_hs);
      w_q <= wr_go ? 1'b0 : (w_q || w_hs);
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end

  // ------------------------------------------------------------
  // control, status and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_q <= `LET_CTRL_RST;
      mask_q <= `LET_MASK_RST;
      local_ed_q <= 32'(ED_DEF_MS);
      status_q <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= (ctrl_q & ~wmask) | (wd & wmask & 32'h0000_0001);
      if (wr_mask)
        mask_q <= (mask_q & ~wmask[LET_NCH-1:0]) | (wd[LET_NCH-1:0] & wmask[LET_NCH-1:0]);
      if (wr_led)
        local_ed_q <= (local_ed_q & ~wmask) | (wd & wmask);
      // a new expiry wins over a clear in the same cycle
      status_q <= (status_q & ~w1c) | expire;
    end

  assign irq = |(status_q & mask_q);

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire [31:0] info = {30'h0, logged_q, ed_q.res_ns};
  wire rd_hit = (s_axi_araddr <= `LET_OFF_INFO) && (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rd_mux =
    (s_axi_araddr == `LET_OFF_CTRL) ? ctrl_q :
    (s_axi_araddr == `LET_OFF_STATUS) ? 32'(status_q) :
    (s_axi_araddr == `LET_OFF_MASK) ? 32'(mask_q) :
    (s_axi_araddr == `LET_OFF_LOCAL_ED) ? local_ed_q :
    (s_axi_araddr == `LET_OFF_ED_VAL) ? ed_q.value :
    (s_axi_araddr == `LET_OFF_INFO) ? info : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end
    else if (ar_hs)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;

  // ------------------------------------------------------------
  // timeout value report
  // ------------------------------------------------------------
  // sub-millisecond values only fit in ns units
  wire let_tov_t rt_rep = short_rt ? '{value: 32'(`LET_RT_SHORT_NS), res_ns: 1'b1} :
    (RT_LONG_US % `LET_MS_US == 0) ? '{value: 32'(RT_LONG_US / `LET_MS_US), res_ns: 1'b0} :
    '{value: 32'(RT_LONG_US * `LET_US_NS), res_ns: 1'b1};

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      link_service_accept <= '0;
    else
    begin
      link_service_accept.valid <= read_timeout_value_request;
      if (read_timeout_value_request)
      begin
        link_service_accept.rt <= rt_rep;
        link_service_accept.ed <= ed_q;
      end
    end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_RT_WINDOW: assert property (
    expire[LET_CH_RT] |-> cnt_q[LET_CH_RT] == rt_us)
    else $error("sync loss timer fired at wrong count");
  AST_SHORT_ADV: assert property (
    $rose(adv_short_rt) |-> rt_us == TW'(`LET_RT_SHORT_US))
    else $error("short timeout advertised but not applied");
  AST_DEFAULT_ED: assert property (
    !logged_q |-> ed_us == TW'(ED_DEF_MS) * TW'(`LET_MS_US))
    else $error("error-detect default wrong before login");
  AST_FABRIC: assert property (
    login.valid && login.fabric |=> ed_q == $past(login.ed))
    else $error("fabric value not adopted");
  AST_P2P_MAX: assert property (
    login.valid && !login.fabric |=> ed_us >= $past(peer_us) && ed_us >= $past(own_us))
    else $error("point-to-point did not take the longer value");
  AST_UPPER: assert property (
    expire[LET_CH_SEQ] |-> cnt_q[LET_CH_SEQ] + TW'(1) < ed_us || ed_us <= TW'(1))
    else $error("sequence deadline not ahead of a full period");
  AST_FULL_WAIT: assert property (
    expire[LET_CH_EXPIRE] |-> cnt_q[LET_CH_EXPIRE] >= ed_us)
    else $error("expiry before full error-detect period");
  AST_RA_TWICE: assert property (
    expire[LET_CH_RA] |-> cnt_q[LET_CH_RA] >= (ed_us << 1))
    else $error("resource timeout shorter than twice error-detect");
  AST_STICKY: assert property (
    status_q[LET_CH_ACK] && !w1c[LET_CH_ACK] |=> status_q[LET_CH_ACK])
    else $error("expiry flag dropped without clear");
  AST_REPORT: assert property (
    read_timeout_value_request |=> link_service_accept.valid
      && link_service_accept.ed == $past(ed_q))
    else $error("report missing or wrong");
  AST_IRQ: assert property (
    $rose(irq) |-> $past(|expire) || $past(wr_mask))
    else $error("interrupt without cause");

  COV_RT: cover property (expire[LET_CH_RT]);
  COV_P2P: cover property (login.valid && !login.fabric && peer_longer);
  COV_W1C_RACE: cover property (|(w1c & expire));
  COV_REPORT: cover property (read_timeout_value_request ##1 link_service_accept.valid);

endmodule

// ### tb/let_peer.sv
// peer port model: login offers and timeout value requests
`timescale 1ns/1ps
module let_peer
  import let_pkg::*;
(
  // clock
  input wire logic clk,
  // link side
  output let_login_t login,
  output logic rtv_req,
  input wire let_rtv_t acc
);
  initial
  begin
    login = '0;
    rtv_req = 1'b0;
  end

  // ------------------------------------------------------------
  // login offer, sent after a random pause of up to three cycles
  // ------------------------------------------------------------
  task automatic offer(input logic fab, input logic [31:0] v, input logic ns);
    repeat ($urandom_range(3)) @(posedge clk);
    login <= '{1'b1, fab, '{v, ns}};
    @(posedge clk);
    // released fields never keep the offered value
    login <= '{1'b0, ~fab, '{~v, ~ns}};
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // timeout value request, answer caught while its pulse stands
  // ------------------------------------------------------------
  task automatic ask(output let_rtv_t a);
    a = '0;
    @(posedge clk);
    rtv_req <= 1'b1;
    @(posedge clk);
    rtv_req <= 1'b0;
    repeat (4)
    begin
      @(negedge clk);
      if (acc.valid === 1'b1)
      begin
        a = acc;
        break;
      end
    end
  endtask
endmodule

// ### tb/tb.sv
// self-checking bench of the link timeout block
`timescale 1ns/1ps
module tb
  import let_pkg::*;
;
  localparam int TK = 2;
  localparam int RTL = 200;
  localparam int EDM = 1;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd_v;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, adv, rtv_req;
  logic [1:0] bresp, rresp, rs;
  logic [5:0] run = '0, st = '0, expire;
  let_login_t login;
  let_rtv_t acc, ans;
  int num_errors = 0, n_checks = 0, cyc;
  always #10 clk = ~clk;

  let_top #(.TICK_CYC(TK), .RT_LONG_US(RTL), .ED_DEF_MS(EDM)) DUT (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_sync(~run[0]), .seq_active(run[1]), .tx_data_frame(st[1]),
    .busy_pending(run[2]), .tx_retry(st[2]), .ack_pending(run[3]), .tx_ack(st[3]),
    .wait_run(run[4]), .wait_start(st[4]), .ra_run(run[5]), .ra_start(st[5]),
    .login(login), .read_timeout_value_request(rtv_req), .link_service_accept(acc),
    .adv_short_rt(adv), .expire(expire), .irq(irq));

  let_peer peer (.clk(clk), .login(login), .rtv_req(rtv_req), .acc(acc));

  // ------------------------------------------------------------
  // comparison, verdict and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, pb;
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      pa = awvalid & awready;
      pw = wvalid & wready;
      pb = bvalid & bready;
      r = bresp;
      @(posedge clk);
      if (pa)
        awvalid <= 1'b0;
      if (pw)
        wvalid <= 1'b0;
      n++;
    end while (pb !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (pb !== 1'b1)
      num_errors++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, pb;
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      pa = arvalid & arready;
      pb = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (pa)
        arvalid <= 1'b0;
      n++;
    end while (pb !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (pb !== 1'b1)
      num_errors++;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_v, rs);
    chk({rs, rd_v}, {2'b00, e});
  endtask

  // run one channel until its expiry pulse, counting cycles
  task automatic time_ch(input int idx, input int lim, output int c);
    c = 0;
    @(posedge clk);
    run[idx] <= 1'b1;
    while (c < lim)
    begin
      @(negedge clk);
      c++;
      if (expire[idx] === 1'b1)
        break;
    end
    @(posedge clk);
    run[idx] <= 1'b0;
  endtask

  function automatic logic in_win(int c, int lo);
    return c >= lo && c * 5 <= lo * 6;
  endfunction

  // longer of a peer offer and our own 1 ms offer, kept raw
  function automatic logic [32:0] longer(logic [31:0] v, logic ns);
    int unsigned us;
    us = ns ? (v + 999) / 1000 : v * 1000;
    return us > 1000 ? {v, ns} : {32'd1, 1'b0};
  endfunction

  initial
  begin
    #1ms;
    num_errors++;
    final_report();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [32:0] e;
    logic [31:0] v;
    void'($urandom(32'hB9513110));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'h00, 0);
    rdc(8'h04, 0);
    rdc(8'h08, 0);
    rdc(8'h0C, EDM);
    rdc(8'h10, EDM);
    rdc(8'h14, 0);
    chk({irq, adv}, 0);
    rd(8'h20, rd_v, rs);
    chk(rs, 2'b10);
    wr(8'h10, 32'h5, rs);
    chk(rs, 2'b10);
    rdc(8'h10, EDM);
    peer.ask(ans);
    // long value of the bench is under a millisecond, so it reports in ns
    chk(ans.rt, (RTL % 1000 == 0) ? {32'(RTL / 1000), 1'b0} : {32'(RTL * 1000), 1'b1});
    chk(ans.ed, {32'(EDM), 1'b0});
    $display("test reset and map done");
    peer.offer(1'b1, 32'd50000, 1'b1);
    rdc(8'h10, 32'd50000);
    rdc(8'h14, 32'h3);
    peer.ask(ans);
    chk(ans.ed, {32'd50000, 1'b1});
    $display("test fabric login done");
    time_ch(4, 300, cyc);
    chk(in_win(cyc, 100), 1);
    time_ch(5, 600, cyc);
    chk(in_win(cyc, 200), 1);
    for (int i = 1; i < 4; i++)
    begin
      time_ch(i, 300, cyc);
      chk(cyc < 100 && cyc * 10 >= 900, 1);
    end
    cyc = 0;
    @(posedge clk);
    run[1] <= 1'b1;
    repeat (5)
    begin
      @(posedge clk);
      st[1] <= 1'b1;
      @(posedge clk);
      st[1] <= 1'b0;
      repeat (80) @(negedge clk) cyc += expire[1];
    end
    chk(cyc, 0);
    time_ch(1, 300, cyc);
    // expiry counts from the last restart, 80 cycles before this timing began
    chk(cyc + 80 < 100 && cyc + 80 >= 90, 1);
    $display("test error-detect timers done");
    time_ch(0, 1200, cyc);
    chk(in_win(cyc, 2 * RTL), 1);
    wr(8'h00, 32'h1, rs);
    chk({adv, rs}, 3'b100);
    peer.ask(ans);
    chk(ans.rt, {32'd100000, 1'b1});
    time_ch(0, 600, cyc);
    chk(in_win(cyc, 200), 1);
    $display("test sync-loss timer done");
    rdc(8'h04, 32'h3F);
    chk(irq, 0);
    wr(8'h08, 32'h1, rs);
    @(negedge clk);
    chk(irq, 1);
    wr(8'h04, 32'h3F, rs);
    rdc(8'h04, 0);
    chk(irq, 0);
    $display("test interrupt done");
    wr(8'h0C, 32'h1, rs);
    for (int i = 0; i < 5; i++)
    begin
      v = i[0] ? $urandom_range(900000, 1) : $urandom_range(2000000, 1100000);
      if (i == 0)
        v = 2;
      e = longer(v, i != 0);
      peer.offer(1'b0, v, i != 0);
      rdc(8'h10, e[32:1]);
      rdc(8'h14, {30'd0, 1'b1, e[0]});
    end
    $display("test point-to-point login done");
    final_report();
  end
endmodule
